/* File: lcdcd_pkg.sv */
// Package: constants and types for the LCD command decoder
package lcdcd_pkg;

  // ------------------------------------------------------------
  // Command codes and masks
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] CMD_DISP_ON = 8'haf;
  localparam logic [7:0] CMD_SEG_DIR = 8'ha0;
  localparam logic [7:0] CMD_BIAS = 8'ha2;
  localparam logic [7:0] CMD_ALL_ON = 8'ha4;
  localparam logic [7:0] CMD_REVERSE = 8'ha6;
  localparam logic [7:0] CMD_IND = 8'hac;
  localparam logic [7:0] CMD_EVOL_MODE = 8'h81;
  localparam logic [7:0] CMD_RMW = 8'he0;
  localparam logic [7:0] CMD_END = 8'hee;
  localparam logic [7:0] CMD_SOFT_RST = 8'he2;
  localparam logic [7:0] CMD_NOP = 8'he3;
  localparam logic [7:0] MASK_D0 = 8'hfe;
  localparam logic [7:0] MASK_3B = 8'hf8;
  localparam logic [7:0] CMD_RATIO = 8'h20;
  localparam logic [7:0] CMD_POWER = 8'h28;
  localparam logic [7:0] CMD_COM_DIR = 8'hc0;
  localparam logic [3:0] HI_COL_HI = 4'h1;
  localparam logic [3:0] HI_COL_LO = 4'h0;
  localparam logic [3:0] HI_PAGE = 4'hb;
  localparam logic [3:0] HI_COM = 4'hc;
  localparam logic [3:0] HI_TEST = 4'hf;
  localparam logic [1:0] HI_START = 2'h1;

  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [7:0] COL_MAX = 8'h83;
  localparam logic [7:0] COL_RST = 8'h00;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [5:0] LINE_RST = 6'h00;
  localparam logic [5:0] EVOL_RST = 6'h20;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [2:0] POWER_RST = 3'h0;
  localparam logic [1:0] IND_RST = 2'h0;

  // Bias denominators from 1/9 down to 1/5; duty and D0 select one
  localparam logic [3:0] BIAS_9 = 4'h9;
  localparam logic [3:0] BIAS_8 = 4'h8;
  localparam logic [3:0] BIAS_7 = 4'h7;
  localparam logic [3:0] BIAS_6 = 4'h6;
  localparam logic [3:0] BIAS_5 = 4'h5;

  // ------------------------------------------------------------
  // Blink timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 250;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CLK_KHZ;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DUTY_65, DUTY_49, DUTY_33, DUTY_55, DUTY_53
  } lcdcd_duty_type;

  typedef enum logic [1:0] {
    IND_OFF, IND_SLOW, IND_FAST, IND_STEADY
  } lcdcd_ind_type;

  typedef enum logic [1:0] {
    PEND_NONE, PEND_EVOL, PEND_IND
  } lcdcd_pend_type;

  // Host bus request
  typedef struct packed {
    logic cmd_data_select;
    logic wr;
    logic rd;
    logic [7:0] data;
  } lcdcd_req_type;

endpackage

/* File: lcdcd_blink.sv */
// Static indicator blink generator
`timescale 1ns/1ns
module lcdcd_blink #(
  parameter int unsigned SLOW_HALF = lcdcd_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = lcdcd_pkg::FAST_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Mode and output
  input wire lcdcd_pkg::lcdcd_ind_type mode,
  output logic blink_out
);
  import lcdcd_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
    logic out;
  } lcdcd_blink_type;

  lcdcd_blink_type s_q;
  lcdcd_blink_type s_d;

  // ------------------------------------------------------------
  // Half-period counter
  // ------------------------------------------------------------
  // Counter idles while off or steady; a rate change keeps the count, so
  // the first half period after it may be short
  always_comb
  begin
    logic [31:0] lim;
    lim = (mode == IND_FAST) ? (FAST_HALF - 32'd1) : (SLOW_HALF - 32'd1);
    s_d = s_q;
    if (mode == IND_OFF || mode == IND_STEADY)
    begin
      s_d.cnt = 32'h0;
      s_d.phase = 1'b1;
    end
    else if (s_q.cnt >= lim)
    begin
      s_d.cnt = 32'h0;
      s_d.phase = ~s_q.phase;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'd1;
    end
    unique case (mode)
      IND_OFF: s_d.out = 1'b0;
      IND_STEADY: s_d.out = 1'b1;
      default: s_d.out = s_q.phase;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      s_q <= '{cnt: 32'h0, phase: 1'b1, out: 1'b0};
    else
      s_q <= s_d;
  end

  assign blink_out = s_q.out;

endmodule // lcdcd_blink

/* File: lcdcd_top.sv */
// LCD controller command decoder: command interpreter and display settings
// Functional notes
// RULE1 - D0 of segment direction reverses column mapping
// RULE2 - Column address increments by one per access
// RULE3 - Reverse mode inverts pixels, RAM untouched
// RULE4 - All-points-on forces pixels, beats reverse
// RULE5 - All-on while display off enters power save
// RULE6 - Bias from D0 and configured duty
// RULE7 - Read/modify/write: reads hold, writes increment column
// RULE8 - End leaves mode, restores saved column
// RULE9 - Host avoids column set during read/modify/write
// RULE10 - Soft reset initialises listed state, not RAM
// RULE11 - Host powers up with hardware reset pin
// RULE12 - Common mode selects ascending or descending scan
// RULE13 - Power bits drive booster, regulator, follower
// RULE14 - Three-bit resistor ratio stored, zero smallest
// RULE15 - Host sends volume mode and value paired
// RULE16 - After volume mode, next byte is value
// RULE17 - Six-bit volume loaded, mode then left
// RULE18 - Host programs volume even when unused
// RULE19 - Indicator changed only by indicator commands; the soft reset here also clears it to off
// RULE20 - Indicator on needs register byte, off not
// RULE21 - After indicator on, next byte is register
// RULE22 - Two-bit indicator register selects blinking
// RULE23 - Indicator codes: off, 1 s, 0.5 s, on
// RULE24 - Column stops at maximum, page never advances
// RULE25 - Command bytes have select low, no busy
`timescale 1ns/1ns
module lcdcd_top #(
  parameter int unsigned SLOW_HALF = lcdcd_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = lcdcd_pkg::FAST_HALF_CYC
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hardware_init_pin_n,
  // Host bus
  input wire lcdcd_pkg::lcdcd_req_type host_req,
  output logic [7:0] host_rdata,
  // Display RAM side
  input wire logic [7:0] ram_rdata,
  output logic ram_wr,
  output logic [7:0] ram_wdata,
  output logic [7:0] ram_col,
  output logic [3:0] ram_page,
  output logic [5:0] start_line,
  // Pixel and column mapping
  input wire logic ram_pixel,
  output logic pixel_on,
  input wire logic [7:0] seg_index,
  output logic [7:0] seg_col,
  // Drive configuration
  input wire lcdcd_pkg::lcdcd_duty_type duty_sel,
  output logic display_on,
  output logic com_reverse,
  output logic [3:0] bias_denom,
  output logic [2:0] power_ctrl,
  output logic [2:0] resistor_ratio,
  output logic [5:0] evol_level,
  // Power save and indicator
  output logic power_save,
  output logic sleep_mode,
  output logic standby_mode,
  output logic test_mode,
  output logic indicator_segment_out
);
  import lcdcd_pkg::*;

  typedef struct packed {
    logic disp_on;
    logic seg_rev;
    logic reverse;
    logic all_on;
    logic bias_d0;
    logic com_rev;
    logic rmw;
    logic test;
    logic [7:0] col;
    logic [7:0] col_saved;
    logic [3:0] page;
    logic [5:0] line;
    logic [2:0] power;
    logic [2:0] ratio;
    logic [5:0] evol;
    lcdcd_ind_type ind;
    lcdcd_pend_type pend;
    logic [7:0] rdata;
    logic ram_wr;
    logic [7:0] wdata;
  } lcdcd_state_type;

  lcdcd_state_type s_q;
  lcdcd_state_type s_d;
  logic rst_all;
  logic cmd_wr;
  logic [7:0] b;

  // Pin reset acts as a second synchronous reset source
  assign rst_all = sys_rst | ~hardware_init_pin_n;
  assign cmd_wr = host_req.wr & ~host_req.cmd_data_select; // see RULE25
  assign b = host_req.data;

  // ------------------------------------------------------------
  // Command decode and next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ram_wr = 1'b0;
    // Data accesses; reads in read/modify/write keep the column
    if (host_req.wr && host_req.cmd_data_select)
    begin
      s_d.ram_wr = 1'b1;
      s_d.wdata = b;
      if (s_q.col < COL_MAX)
        s_d.col = s_q.col + 8'd1; // see RULE2 RULE7 RULE24
    end
    if (host_req.rd)
    begin
      if (host_req.cmd_data_select)
      begin
        s_d.rdata = ram_rdata;
        if (!s_q.rmw && s_q.col < COL_MAX)
          s_d.col = s_q.col + 8'd1; // see RULE2 RULE7 RULE24
      end
      else
        s_d.rdata = {1'b0, ~s_q.seg_rev, ~s_q.disp_on, 5'h00};
    end
    if (cmd_wr)
    begin
      // A pending double-byte command swallows the next command byte
      if (s_q.pend == PEND_EVOL)
      begin
        s_d.evol = b[5:0]; // see RULE16 RULE17
        s_d.pend = PEND_NONE; // see RULE17
      end
      else if (s_q.pend == PEND_IND)
      begin
        s_d.ind = lcdcd_ind_type'(b[1:0]); // see RULE21 RULE22
        s_d.pend = PEND_NONE; // see RULE21
      end
      else if ((b & MASK_D0) == CMD_DISP_OFF)
        s_d.disp_on = b[0];
      else if ((b & MASK_D0) == CMD_SEG_DIR)
        s_d.seg_rev = b[0]; // see RULE1
      else if ((b & MASK_D0) == CMD_REVERSE)
        s_d.reverse = b[0]; // see RULE3
      else if ((b & MASK_D0) == CMD_ALL_ON)
        s_d.all_on = b[0]; // see RULE4
      else if ((b & MASK_D0) == CMD_BIAS)
        s_d.bias_d0 = b[0]; // see RULE6
      else if ((b & MASK_D0) == CMD_IND)
      begin
        // Off is complete at once; on waits for the register byte
        if (b[0])
          s_d.pend = PEND_IND; // see RULE20
        else
          s_d.ind = IND_OFF; // see RULE19 RULE20
      end
      else if (b == CMD_EVOL_MODE)
        s_d.pend = PEND_EVOL; // see RULE16
      else if (b == CMD_RMW)
      begin
        s_d.rmw = 1'b1;
        s_d.col_saved = s_q.col; // see RULE8
      end
      else if (b == CMD_END)
      begin
        if (s_q.rmw)
          s_d.col = s_q.col_saved; // see RULE8
        s_d.rmw = 1'b0; // see RULE8
      end
      else if (b == CMD_SOFT_RST)
      begin
        s_d.line = LINE_RST; // see RULE10
        s_d.col = COL_RST;
        s_d.page = PAGE_RST;
        s_d.com_rev = 1'b0;
        s_d.ratio = RATIO_RST;
        s_d.evol = EVOL_RST;
        s_d.ind = IND_OFF;
        s_d.rmw = 1'b0;
        s_d.test = 1'b0;
      end
      else if (b == CMD_NOP)
        s_d.test = 1'b0;
      else if (b[7:4] == HI_TEST)
        s_d.test = 1'b1;
      else if (b[7:4] == HI_COM)
        s_d.com_rev = b[3]; // see RULE12
      else if (b[7:4] == HI_PAGE)
        s_d.page = b[3:0];
      else if (b[7:6] == HI_START)
        s_d.line = b[5:0];
      else if ((b & MASK_3B) == CMD_POWER)
        s_d.power = b[2:0]; // see RULE13
      else if ((b & MASK_3B) == CMD_RATIO)
        s_d.ratio = b[2:0]; // see RULE14
      // Column set is trusted not to arrive in read/modify/write mode
      else if (b[7:4] == HI_COL_HI)
        s_d.col = {b[3:0], s_q.col[3:0]}; // see RULE9
      else if (b[7:4] == HI_COL_LO)
        s_d.col = {s_q.col[7:4], b[3:0]}; // see RULE9
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Pin reset restores every setting; the command only a subset
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      s_q <= '{disp_on: 1'b0, seg_rev: 1'b0, reverse: 1'b0, all_on: 1'b0,
               bias_d0: 1'b0, com_rev: 1'b0, rmw: 1'b0, test: 1'b0,
               col: COL_RST, col_saved: COL_RST, page: PAGE_RST,
               line: LINE_RST, power: POWER_RST, ratio: RATIO_RST,
               evol: EVOL_RST, ind: IND_OFF, pend: PEND_NONE,
               rdata: 8'h00, ram_wr: 1'b0, wdata: 8'h00};
    end
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign host_rdata = s_q.rdata;
  assign ram_wr = s_q.ram_wr;
  assign ram_wdata = s_q.wdata;
  assign ram_col = s_q.col;
  assign ram_page = s_q.page; // see RULE24
  assign start_line = s_q.line;
  assign display_on = s_q.disp_on;
  assign com_reverse = s_q.com_rev; // see RULE12
  assign power_ctrl = s_q.power; // see RULE13
  assign resistor_ratio = s_q.ratio; // see RULE14
  assign evol_level = s_q.evol; // see RULE17
  assign test_mode = s_q.test;

  // Forced-on wins over inversion so the panel is fully dark-lit
  assign pixel_on = s_q.all_on | (ram_pixel ^ s_q.reverse); // see RULE3 RULE4
  // Reverse mapping mirrors around the last column
  assign seg_col = s_q.seg_rev ? (COL_MAX - seg_index) : seg_index; // see RULE1
  // Power save is the compound of display off and all points on
  assign power_save = ~s_q.disp_on & s_q.all_on; // see RULE5
  assign sleep_mode = power_save & (s_q.ind == IND_OFF);
  assign standby_mode = power_save & (s_q.ind != IND_OFF);

  // Bias table by duty
  always_comb
  begin
    unique case (duty_sel)
      DUTY_65: bias_denom = s_q.bias_d0 ? BIAS_7 : BIAS_9; // see RULE6
      DUTY_33: bias_denom = s_q.bias_d0 ? BIAS_5 : BIAS_6;
      DUTY_49, DUTY_55, DUTY_53: bias_denom = s_q.bias_d0 ? BIAS_6 : BIAS_8;
      default: bias_denom = BIAS_9;
    endcase
  end

  // Indicator drive; held off in sleep where the oscillator stops
  lcdcd_blink #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF)
  ) u_blink (
    .clk_sys(clk_sys),
    .sys_rst(rst_all),
    .mode(s_q.ind), // see RULE23
    .blink_out(indicator_segment_out)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_cmd(logic [7:0] c);
    cmd_wr && s_q.pend == PEND_NONE && b == c;
  endsequence

  property p_col_inc;
    @(posedge clk_sys) disable iff (rst_all)
    host_req.wr && host_req.cmd_data_select && !cmd_wr && s_q.col < COL_MAX
    |=> s_q.col == $past(s_q.col) + 8'd1;
  endproperty
  a_col_inc: assert property (p_col_inc) else $error("column not incremented"); // see RULE2

  property p_col_sat;
    @(posedge clk_sys) disable iff (rst_all)
    s_q.col == COL_MAX && !cmd_wr |=> s_q.col == COL_MAX && s_q.page == $past(s_q.page);
  endproperty
  a_col_sat: assert property (p_col_sat) else $error("column passed maximum"); // see RULE24

  property p_rmw_read;
    @(posedge clk_sys) disable iff (rst_all)
    s_q.rmw && host_req.rd && host_req.cmd_data_select && !host_req.wr && !cmd_wr
    |=> s_q.col == $past(s_q.col);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("column moved on rmw read"); // see RULE7

  property p_end_restore;
    logic [7:0] saved;
    @(posedge clk_sys) disable iff (rst_all)
    // A soft reset in between drops the mode, which excuses the restore
    (s_cmd(CMD_RMW), saved = s_q.col) ##1 s_q.rmw
    ##[0:300] s_cmd(CMD_END) |=> (s_q.col == saved) || !$past(s_q.rmw);
  endproperty
  a_end_restore: assert property (p_end_restore) else $error("end did not restore"); // see RULE8

  property p_evol_pair;
    @(posedge clk_sys) disable iff (rst_all)
    s_cmd(CMD_EVOL_MODE) ##1 (cmd_wr && s_q.pend == PEND_EVOL)
    |=> s_q.evol == $past(b[5:0]) && s_q.pend == PEND_NONE;
  endproperty
  a_evol_pair: assert property (p_evol_pair) else $error("volume pair mishandled"); // see RULE17

  property p_ind_pend;
    @(posedge clk_sys) disable iff (rst_all)
    cmd_wr && s_q.pend == PEND_IND
    |=> s_q.ind == lcdcd_ind_type'($past(b[1:0])) && s_q.pend == PEND_NONE
        && s_q.disp_on == $past(s_q.disp_on);
  endproperty
  a_ind_pend: assert property (p_ind_pend) else $error("indicator register wrong"); // see RULE21

  property p_all_on;
    @(posedge clk_sys) disable iff (rst_all)
    s_q.all_on |-> pixel_on;
  endproperty
  a_all_on: assert property (p_all_on) else $error("all points not forced"); // see RULE4

  property p_reverse;
    @(posedge clk_sys) disable iff (rst_all)
    !s_q.all_on |-> pixel_on == (ram_pixel != s_q.reverse);
  endproperty
  a_reverse: assert property (p_reverse) else $error("pixel polarity wrong"); // see RULE3

  property p_psave;
    @(posedge clk_sys) disable iff (rst_all)
    s_cmd(8'ha5) ##0 !s_q.disp_on |=> power_save;
  endproperty
  a_psave: assert property (p_psave) else $error("power save not entered"); // see RULE5

  property p_power;
    @(posedge clk_sys) disable iff (rst_all)
    s_cmd({CMD_POWER[7:3], b[2:0]}) |=> power_ctrl == $past(b[2:0]);
  endproperty
  a_power: assert property (p_power) else $error("power bits not stored"); // see RULE13

  property p_soft_rst;
    @(posedge clk_sys) disable iff (rst_all)
    s_cmd(CMD_SOFT_RST) |=> s_q.col == COL_RST && s_q.evol == EVOL_RST && !s_q.rmw
      && s_q.ind == IND_OFF && s_q.disp_on == $past(s_q.disp_on);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset incomplete"); // see RULE10

  property p_bias65;
    @(posedge clk_sys) disable iff (rst_all)
    duty_sel == DUTY_65 |-> bias_denom == (s_q.bias_d0 ? BIAS_7 : BIAS_9);
  endproperty
  a_bias65: assert property (p_bias65) else $error("bias wrong for 1/65"); // see RULE6

endmodule // lcdcd_top

/* File: lcdcd_host.sv */
// Host processor model: command and data cycles on the decoder bus
`timescale 1ns/1ns
module lcdcd_host (
  // Clock
  input wire logic clk_sys,
  // Bus to the decoder
  output lcdcd_pkg::lcdcd_req_type host_req
);
  import lcdcd_pkg::*;

  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial host_req = '{1'b0, 1'b0, 1'b0, 8'h00};

  // One strobe cycle then release; idle data shows the inverse so a
  // stale byte can never pass for a fresh one
  task automatic xfer(input logic sel, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    host_req <= '{sel, w, !w, d};
    @(posedge clk_sys);
    host_req <= '{sel, 1'b0, 1'b0, ~d};
    @(negedge clk_sys);
  endtask

  // Command byte, select low
  task automatic cmd(input logic [7:0] b);
    xfer(1'b0, 1'b1, b);
  endtask

  // Two-byte commands are never split by another byte
  task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
    xfer(1'b0, 1'b1, a);
    xfer(1'b0, 1'b1, b);
  endtask
endmodule // lcdcd_host

/* File: tb.sv */
// Self-checking testbench for the LCD command decoder
`timescale 1ns/1ns
module tb;
  import lcdcd_pkg::*;

  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam int unsigned SLOW = 8;
  localparam int unsigned FAST = 4;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hardware_init_pin_n = 1'b1;
  logic ram_pixel = 1'b0;
  logic [7:0] seg_index = 8'h00;
  lcdcd_duty_type duty_sel = DUTY_65;
  lcdcd_req_type host_req;
  logic [7:0] host_rdata, ram_rdata, ram_wdata, ram_col, seg_col;
  logic ram_wr, pixel_on, display_on, com_reverse, power_save, sleep_mode;
  logic standby_mode, test_mode, indicator_segment_out;
  logic [3:0] ram_page, bias_denom;
  logic [5:0] start_line, evol_level;
  logic [2:0] power_ctrl, resistor_ratio;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // RAM stand-in: each column holds a byte derived from its address
  assign ram_rdata = ram_col ^ 8'h5a;

  lcdcd_host u_host (.clk_sys(clk_sys), .host_req(host_req));

  lcdcd_top #(.SLOW_HALF(SLOW), .FAST_HALF(FAST)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hardware_init_pin_n(hardware_init_pin_n),
    .host_req(host_req), .host_rdata(host_rdata), .ram_rdata(ram_rdata),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_col(ram_col), .ram_page(ram_page),
    .start_line(start_line), .ram_pixel(ram_pixel), .pixel_on(pixel_on),
    .seg_index(seg_index), .seg_col(seg_col), .duty_sel(duty_sel),
    .display_on(display_on), .com_reverse(com_reverse), .bias_denom(bias_denom),
    .power_ctrl(power_ctrl), .resistor_ratio(resistor_ratio), .evol_level(evol_level),
    .power_save(power_save), .sleep_mode(sleep_mode), .standby_mode(standby_mode),
    .test_mode(test_mode), .indicator_segment_out(indicator_segment_out));

  // Clock and hang guard; the whole run needs well under 3000 cycles
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    u_host.cmd(b);
  endtask

  task automatic dat(input logic [7:0] b);
    u_host.xfer(1'b1, 1'b1, b);
  endtask

  task automatic rd(input logic sel);
    u_host.xfer(sel, 1'b0, 8'h00);
  endtask

  // Counts edges between two changes of the indicator output
  task automatic half_period(input int exp);
    int n;
    logic v;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      v = indicator_segment_out;
      // Look between edges so the registered output has settled
      while (indicator_segment_out === v && n < 40)
      begin
        @(negedge clk_sys);
        n++;
      end
    end
    check(8'(n), 8'(exp));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_segdir();
    rd(1'b0);
    check(host_rdata, 8'h60);
    cmd(8'ha1);
    foreach (seg_index[i])
    begin
      @(posedge clk_sys) seg_index <= 8'(i * 18);
      @(negedge clk_sys) check(seg_col, 8'(131 - i * 18));
    end
    rd(1'b0);
    check(host_rdata, 8'h20);
    cmd(8'ha0);
    check(seg_col, seg_index);
    $display("test segdir finished");
  endtask

  // Stops at the last column; page stays put; a data byte never decodes
  task automatic t_column();
    cmd(8'h18);
    cmd(8'h02);
    dat(8'haf);
    check({ram_wr, ram_wdata[6:0]}, 8'haf);
    check(ram_col, 8'h83);
    dat(8'h3c);
    check(ram_col, 8'h83);
    check({ram_page, 3'h0, display_on}, 8'h00);
    cmd(8'h10);
    cmd(8'h05);
    rd(1'b1);
    check(host_rdata, 8'h5f);
    check(ram_col, 8'h06);
    $display("test column finished");
  endtask

  task automatic t_pixel();
    for (int k = 0; k < 8; k++)
    begin
      cmd(8'ha6 | 8'(k[0]));
      cmd(8'ha4 | 8'(k[1]));
      @(posedge clk_sys) ram_pixel <= k[2];
      @(negedge clk_sys) check(8'(pixel_on), 8'(k[1] | (k[2] ^ k[0])));
    end
    cmd(8'ha5);
    check(8'({power_save, sleep_mode, standby_mode}), 8'h06);
    cmd(8'haf);
    check(8'(power_save), 8'h00);
    cmd(8'hae);
    cmd(8'ha4);
    cmd(8'ha6);
    $display("test pixel finished");
  endtask

  task automatic t_bias();
    logic [3:0] tbl [10] = '{4'h9, 4'h7, 4'h8, 4'h6, 4'h6, 4'h5, 4'h8, 4'h6, 4'h8, 4'h6};
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk_sys) duty_sel <= lcdcd_duty_type'(k / 2);
      cmd(8'ha2 | 8'(k % 2));
      check(8'(bias_denom), 8'(tbl[k]));
    end
    cmd(8'ha2);
    @(posedge clk_sys) duty_sel <= DUTY_65;
    $display("test bias finished");
  endtask

  // The host never sets the column while the mode is on
  task automatic t_rmw();
    cmd(8'h11);
    cmd(8'h00);
    cmd(8'he0);
    rd(1'b1);
    check(host_rdata, 8'h4a);
    check(ram_col, 8'h10);
    dat(8'h01);
    dat(8'h02);
    check(ram_col, 8'h12);
    cmd(8'hee);
    check(ram_col, 8'h10);
    $display("test rmw finished");
  endtask

  task automatic t_fields();
    cmd(8'hc8);
    check(8'(com_reverse), 8'h01);
    cmd(8'hc0);
    check(8'(com_reverse), 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      cmd(8'h28 | 8'(k));
      check(8'(power_ctrl), 8'(k));
      cmd(8'h20 | 8'(k));
      check(8'(resistor_ratio), 8'(k));
    end
    $display("test fields finished");
  endtask

  // Value bytes that look like commands must land in the register
  task automatic t_evol();
    u_host.cmd2(8'h81, 8'haf);
    check({display_on, 1'b0, evol_level}, 8'h2f);
    u_host.cmd2(8'h81, 8'h3f);
    check(8'(evol_level), 8'h3f);
    cmd(8'haf);
    check(8'(display_on), 8'h01);
    cmd(8'hae);
    u_host.cmd2(8'h81, 8'h20);
    check(8'(evol_level), 8'h20);
    $display("test evol finished");
  endtask

  task automatic t_indicator();
    u_host.cmd2(8'had, 8'ha7);
    repeat (3) @(negedge clk_sys);
    check(8'({indicator_segment_out, pixel_on}), 8'h03);
    cmd(8'ha7);
    cmd(8'ha5);
    check(8'({indicator_segment_out, standby_mode, sleep_mode}), 8'h06);
    cmd(8'ha4);
    cmd(8'ha6);
    u_host.cmd2(8'had, 8'h01);
    half_period(SLOW);
    u_host.cmd2(8'had, 8'h02);
    half_period(FAST);
    cmd(8'hac);
    cmd(8'haf);
    repeat (3) @(negedge clk_sys);
    check(8'({indicator_segment_out, display_on}), 8'h01);
    cmd(8'hae);
    $display("test indicator finished");
  endtask

  task automatic t_softrst();
    cmd(8'h45);
    cmd(8'hb3);
    cmd(8'hc8);
    cmd(8'h25);
    cmd(8'h2f);
    cmd(8'haf);
    u_host.cmd2(8'h81, 8'h11);
    u_host.cmd2(8'had, 8'h03);
    cmd(8'h11);
    cmd(8'h04);
    cmd(8'he0);
    cmd(8'hf0);
    check(8'(test_mode), 8'h01);
    cmd(8'he2);
    repeat (3) @(negedge clk_sys);
    check({start_line, 2'h0}, 8'h00);
    check({ram_col[3:0], ram_page}, 8'h00);
    check(8'({com_reverse, resistor_ratio}), 8'h00);
    check(8'({indicator_segment_out, test_mode}), 8'h00);
    check(8'(evol_level), 8'h20);
    check(8'({display_on, power_ctrl}), 8'h0f);
    rd(1'b1);
    check(ram_col, 8'h01);
    cmd(8'hf0);
    cmd(8'he3);
    check(8'(test_mode), 8'h00);
    $display("test softrst finished");
  endtask

  task automatic t_hwinit();
    cmd(8'ha1);
    @(posedge clk_sys) hardware_init_pin_n <= 1'b0;
    @(posedge clk_sys) hardware_init_pin_n <= 1'b1;
    @(negedge clk_sys) check(8'({display_on, power_ctrl}), 8'h00);
    check(seg_col, seg_index);
    $display("test hwinit finished");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    check({bias_denom, 2'h0, display_on, pixel_on}, 8'h90);
    check(8'(evol_level), 8'h20);
    t_segdir();
    t_column();
    t_pixel();
    t_bias();
    t_rmw();
    t_fields();
    t_evol();
    t_indicator();
    t_softrst();
    t_hwinit();
    tally_and_finish();
  end
endmodule // tb
